// ---- core/rtfc_top.sv ----
// Feature control of a Gen2v2 tag: memory safeguard, select features,
// self adjust, backscatter, pre-serialised EPC and Untraceable.
// Assumes all command pulses come decoded from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - ECC fixes single, flags double errors
// - EPC check, fix, double flags; raw on double
// - User check, fix, double flags; raw on double
// - Lock on the EPC or User bank enables its ECC
// - Secured write to password-locked bank kills ECC
// - Lock checks margin except on TID, else error, no lock
// - Capacitance steps upward; disable forces centre
// - Brand select gives PC, EPC, brand, CRC
// - Brand code sent XORed with RN16
// - Brand select always matches, PC adjusted
// - Brand and EPC plus TID are exclusive
// - EPC plus TID select extends ACK reply
// - Flag select: only flagged tags reply
// - Max backscatter default; cleared bit reduces
// - Delivered EPC is TID with header zeroed
// - Untraceable frame field order and widths
// - Untraceable only in secured; state table
// - TID hide some, EPC length, U ignored
// - Hidden memory in open gives overrun
// - Range toggle reverts after power loss
// - Action select needs exact pointer, length, mask
// - Permanent bits toggle on single write one
// - Indicator bits are read only
module rtfc_top import rtfc_pkg::*; #(
  parameter logic [15:0] BRAND_CODE = 16'h5a3c // Arbitrary value
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire rtfc_state_e tag_state,
  input  wire logic        epc_permalocked,
  input  wire rtfc_sel_s   sel,
  input  wire rtfc_lock_s  lock,
  input  wire rtfc_wr_s    wr,
  input  wire rtfc_untr_s  untr,
  input  wire rtfc_rd_s    rd,
  input  wire logic        ack_pulse,
  input  wire logic [15:0] rn16,
  input  wire logic [95:0] tid_rom,
  input  wire logic [10:0] pc_low,
  input  wire logic        sa_step,
  output logic      [15:0] conf_word,
  output logic             sel_done,
  output logic             sel_match,
  output logic             lock_done,
  output logic             lock_error,
  output logic             rd_valid,
  output logic      [15:0] rd_data,
  output logic             rd_overrun,
  output logic             reply_valid,
  output rtfc_reply_e      reply_kind,
  output logic      [15:0] pc_word,
  output logic      [15:0] brand_word,
  output logic             backscatter_max,
  output rtfc_cap_e        cap_sel,
  output logic             untr_done,
  output logic             state_valid,
  output rtfc_state_e      state_next,
  output logic             range_reduced,
  output logic      [95:0] preset_epc
);

  // Memory safeguard state
  logic [3:0]  locked_reg, locked_next;
  logic [3:0]  pwd_reg, pwd_next;
  logic [3:0]  ecc_on_reg, ecc_on_next;
  logic        epc_sgl_reg, epc_sgl_next;
  logic        epc_dbl_reg, epc_dbl_next;
  logic        usr_sgl_reg, usr_sgl_next;
  logic        usr_dbl_reg, usr_dbl_next;
  logic        lock_done_reg, lock_done_next;
  logic        lock_err_reg, lock_err_next;
  logic        rd_valid_reg, rd_valid_next;
  logic [15:0] rd_data_reg, rd_data_next;
  logic        rd_ovr_reg, rd_ovr_next;

  // Configuration, select and reply state
  logic        sa_dis_reg, sa_dis_next;
  logic        bs_max_reg, bs_max_next;
  logic        psf_reg, psf_next;
  logic        psf_filt_reg, psf_filt_next;
  rtfc_reply_e act_reg, act_next;
  logic        sel_done_reg, sel_done_next;
  logic        sel_match_reg, sel_match_next;
  logic        reply_valid_reg, reply_valid_next;
  rtfc_reply_e reply_kind_reg, reply_kind_next;
  logic [15:0] pc_word_reg, pc_word_next;
  logic [15:0] brand_word_reg, brand_word_next;
  logic [15:0] conf_reg, conf_next;
  logic [95:0] preset_reg, preset_next;

  // Untraceable state
  logic        untr_done_reg, untr_done_next;
  logic        st_valid_reg, st_valid_next;
  rtfc_state_e st_reg, st_next;
  logic [4:0]  epc_len_reg, epc_len_next;
  logic        epc_hide_reg, epc_hide_next;
  logic [1:0]  tid_hide_reg, tid_hide_next;
  logic        usr_hide_reg, usr_hide_next;
  logic        rng_perm_reg, rng_perm_next;
  logic        rng_tog_reg, rng_tog_next;
  logic        rng_red_reg, rng_red_next;

  logic        ecc_en;
  logic [15:0] dec_data;
  logic        dec_sgl;
  logic        dec_dbl;
  logic        hidden;
  logic        cw_wr;
  logic        act_sel;
  logic        untr_exec;
  rtfc_cap_e   cap;

  assign ecc_en = rd.valid && ecc_on_reg[rd.bank];

  rtfc_ecc u_ecc (
    .code   (rd.code),
    .en     (ecc_en),
    .data   (dec_data),
    .single (dec_sgl),
    .double (dec_dbl)
  );

  rtfc_self_adjust u_sa (
    .clk         (clk),
    .rstn        (rstn),
    .disable_adj (sa_dis_reg),
    .step        (sa_step),
    .cap         (cap)
  );

  // Hidden words only vanish in the open state
  always_comb begin
    hidden = 1'b0;
    if (tag_state == TS_OPEN) begin
      case (rd.bank)
        BANK_EPC:  hidden = epc_hide_reg && rd.addr >= EPC_FIRST + {3'h0, epc_len_reg};
        BANK_TID:  hidden = tid_hide_reg == TID_ALL ||
                            (tid_hide_reg == TID_SOME && rd.addr >= TID_HIDE_FROM);
        BANK_USER: hidden = usr_hide_reg;
        default:   hidden = 1'b0;
      endcase
    end
  end

  always_comb begin
    locked_next    = locked_reg;
    pwd_next       = pwd_reg;
    ecc_on_next    = ecc_on_reg;
    epc_sgl_next   = epc_sgl_reg;
    epc_dbl_next   = epc_dbl_reg;
    usr_sgl_next   = usr_sgl_reg;
    usr_dbl_next   = usr_dbl_reg;
    lock_done_next = 1'b0;
    lock_err_next  = 1'b0;
    rd_valid_next  = rd.valid;
    rd_data_next   = rd_data_reg;
    rd_ovr_next    = 1'b0;
    if (lock.valid) begin
      if (!lock.lock) begin
        locked_next[lock.bank] = 1'b0;
        ecc_on_next[lock.bank] = 1'b0;
        lock_done_next         = 1'b1;
      end else if (!lock.margin_ok && lock.bank != BANK_TID) begin
        lock_err_next = 1'b1;
      end else begin
        lock_done_next         = 1'b1;
        locked_next[lock.bank] = 1'b1;
        pwd_next[lock.bank]    = lock.pwd;
        // A relock without unlock leaves a disabled ECC off
        if (!locked_reg[lock.bank] &&
            (lock.bank == BANK_EPC || lock.bank == BANK_USER)) begin
          ecc_on_next[lock.bank] = 1'b1;
        end
      end
    end
    if (wr.valid && tag_state == TS_SECURED && locked_reg[wr.bank] && pwd_reg[wr.bank]) begin
      ecc_on_next[wr.bank] = 1'b0;
    end
    if (rd.valid) begin
      if (hidden) begin
        rd_ovr_next  = 1'b1;
        rd_data_next = 16'h0000;
      end else begin
        rd_data_next = dec_data;
      end
      if (rd.bank == BANK_EPC) begin
        epc_sgl_next = epc_sgl_reg | dec_sgl;
        epc_dbl_next = epc_dbl_reg | dec_dbl;
      end
      if (rd.bank == BANK_USER) begin
        usr_sgl_next = usr_sgl_reg | dec_sgl;
        usr_dbl_next = usr_dbl_reg | dec_dbl;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      locked_reg    <= 4'h0;
      pwd_reg       <= 4'h0;
      ecc_on_reg    <= 4'h0;
      epc_sgl_reg   <= 1'b0;
      epc_dbl_reg   <= 1'b0;
      usr_sgl_reg   <= 1'b0;
      usr_dbl_reg   <= 1'b0;
      lock_done_reg <= 1'b0;
      lock_err_reg  <= 1'b0;
      rd_valid_reg  <= 1'b0;
      rd_data_reg   <= 16'h0000;
      rd_ovr_reg    <= 1'b0;
    end else begin
      locked_reg    <= locked_next;
      pwd_reg       <= pwd_next;
      ecc_on_reg    <= ecc_on_next;
      epc_sgl_reg   <= epc_sgl_next;
      epc_dbl_reg   <= epc_dbl_next;
      usr_sgl_reg   <= usr_sgl_next;
      usr_dbl_reg   <= usr_dbl_next;
      lock_done_reg <= lock_done_next;
      lock_err_reg  <= lock_err_next;
      rd_valid_reg  <= rd_valid_next;
      rd_data_reg   <= rd_data_next;
      rd_ovr_reg    <= rd_ovr_next;
    end
  end

  // Block writes never reach the permanent bits
  assign cw_wr = wr.valid && wr.single && wr.bank == BANK_EPC && wr.addr == CW_WORD &&
                 !epc_permalocked && (!locked_reg[BANK_EPC] || tag_state == TS_SECURED);
  assign act_sel = sel.valid && !sel.truncate && sel.bank == BANK_EPC &&
                   sel.length == 8'h01 && sel.mask;

  always_comb begin
    sa_dis_next      = sa_dis_reg;
    bs_max_next      = bs_max_reg;
    psf_next         = psf_reg;
    psf_filt_next    = psf_filt_reg;
    act_next         = act_reg;
    sel_done_next    = 1'b0;
    sel_match_next   = 1'b0;
    reply_valid_next = 1'b0;
    reply_kind_next  = reply_kind_reg;
    pc_word_next     = pc_word_reg;
    brand_word_next  = brand_word_reg;
    if (cw_wr) begin
      sa_dis_next = sa_dis_reg ^ wr.data[B_SA_DIS];
      bs_max_next = bs_max_reg ^ wr.data[B_BS_MAX];
      psf_next    = psf_reg ^ wr.data[B_PSF];
    end
    if (act_sel) begin
      case (sel.pointer)
        SEL_EPC_TID: begin
          act_next       = RK_EPC_TID;
          sel_done_next  = 1'b1;
          sel_match_next = 1'b1;
        end
        SEL_BRAND: begin
          act_next       = RK_BRAND;
          sel_done_next  = 1'b1;
          sel_match_next = 1'b1;
        end
        SEL_PSF: begin
          psf_filt_next  = 1'b1;
          sel_done_next  = 1'b1;
          sel_match_next = psf_reg;
        end
        default: sel_done_next = 1'b0;
      endcase
    end
    if (ack_pulse) begin
      reply_valid_next = !psf_filt_reg || psf_reg;
      reply_kind_next  = act_reg;
      brand_word_next  = BRAND_CODE ^ rn16;
      pc_word_next     = {epc_len_reg + {4'h0, act_reg == RK_BRAND}, pc_low};
    end
    // Indicators come from internal state only
    conf_next = {psf_reg, usr_dbl_reg, usr_sgl_reg, ecc_on_reg[BANK_USER], 2'h0,
                 bs_max_reg, 1'b0, sa_dis_reg, cap == CAP_LOW, cap == CAP_HIGH,
                 act_reg == RK_BRAND, act_reg == RK_EPC_TID,
                 epc_dbl_reg, epc_sgl_reg, ecc_on_reg[BANK_EPC]};
    preset_next = {tid_rom[95:64], 16'h0000, tid_rom[47:0]};
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sa_dis_reg      <= RST_SA_DIS;
      bs_max_reg      <= RST_BS_MAX;
      psf_reg         <= RST_PSF;
      psf_filt_reg    <= 1'b0;
      act_reg         <= RK_EPC;
      sel_done_reg    <= 1'b0;
      sel_match_reg   <= 1'b0;
      reply_valid_reg <= 1'b0;
      reply_kind_reg  <= RK_EPC;
      pc_word_reg     <= 16'h0000;
      brand_word_reg  <= 16'h0000;
      conf_reg        <= 16'h0000;
      preset_reg      <= 96'h0;
    end else begin
      sa_dis_reg      <= sa_dis_next;
      bs_max_reg      <= bs_max_next;
      psf_reg         <= psf_next;
      psf_filt_reg    <= psf_filt_next;
      act_reg         <= act_next;
      sel_done_reg    <= sel_done_next;
      sel_match_reg   <= sel_match_next;
      reply_valid_reg <= reply_valid_next;
      reply_kind_reg  <= reply_kind_next;
      pc_word_reg     <= pc_word_next;
      brand_word_reg  <= brand_word_next;
      conf_reg        <= conf_next;
      preset_reg      <= preset_next;
    end
  end

  // RFU codes make the frame not executable
  assign untr_exec = untr.rfu == 2'h0 && untr.tid != FIELD_RFU && untr.range != FIELD_RFU;

  always_comb begin
    untr_done_next = 1'b0;
    st_valid_next  = 1'b0;
    st_next        = st_reg;
    epc_len_next   = epc_len_reg;
    epc_hide_next  = epc_hide_reg;
    tid_hide_next  = tid_hide_reg;
    usr_hide_next  = usr_hide_reg;
    rng_perm_next  = rng_perm_reg;
    rng_tog_next   = rng_tog_reg;
    if (untr.valid && untr.opcode == UNTR_OP) begin
      st_valid_next = 1'b1;
      case (tag_state)
        TS_ARB, TS_REPLY, TS_ACKD: st_next = TS_ARB;
        TS_SECURED: begin
          st_next = TS_SECURED;
          if (untr_exec) begin
            untr_done_next = 1'b1;
            epc_len_next   = untr.epc[4:0];
            epc_hide_next  = untr.epc[5];
            tid_hide_next  = untr.tid;
            usr_hide_next  = untr.user;
            case (untr.range)
              RNG_NORMAL: begin
                rng_perm_next = 1'b0;
                rng_tog_next  = 1'b0;
              end
              RNG_REDUCED: begin
                rng_perm_next = 1'b1;
                rng_tog_next  = 1'b0;
              end
              RNG_TOGGLE: rng_tog_next = ~rng_tog_reg;
              default:    rng_tog_next = rng_tog_reg;
            endcase
          end
        end
        default: st_next = tag_state;
      endcase
    end
    rng_red_next = rng_perm_next ^ rng_tog_next;
  end

  // Toggle is volatile so a power loss undoes it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      untr_done_reg <= 1'b0;
      st_valid_reg  <= 1'b0;
      st_reg        <= TS_READY;
      epc_len_reg   <= RST_EPC_LEN;
      epc_hide_reg  <= 1'b0;
      tid_hide_reg  <= 2'h0;
      usr_hide_reg  <= 1'b0;
      rng_perm_reg  <= RST_RANGE;
      rng_tog_reg   <= 1'b0;
      rng_red_reg   <= RST_RANGE;
    end else begin
      untr_done_reg <= untr_done_next;
      st_valid_reg  <= st_valid_next;
      st_reg        <= st_next;
      epc_len_reg   <= epc_len_next;
      epc_hide_reg  <= epc_hide_next;
      tid_hide_reg  <= tid_hide_next;
      usr_hide_reg  <= usr_hide_next;
      rng_perm_reg  <= rng_perm_next;
      rng_tog_reg   <= rng_tog_next;
      rng_red_reg   <= rng_red_next;
    end
  end

  assign conf_word       = conf_reg;
  assign sel_done        = sel_done_reg;
  assign sel_match       = sel_match_reg;
  assign lock_done       = lock_done_reg;
  assign lock_error      = lock_err_reg;
  assign rd_valid        = rd_valid_reg;
  assign rd_data         = rd_data_reg;
  assign rd_overrun      = rd_ovr_reg;
  assign reply_valid     = reply_valid_reg;
  assign reply_kind      = reply_kind_reg;
  assign pc_word         = pc_word_reg;
  assign brand_word      = brand_word_reg;
  assign backscatter_max = bs_max_reg;
  assign cap_sel         = cap;
  assign untr_done       = untr_done_reg;
  assign state_valid     = st_valid_reg;
  assign state_next      = st_reg;
  assign range_reduced   = rng_red_reg;
  assign preset_epc      = preset_reg;

endmodule
`default_nettype wire

// ---- core/rtfc_pkg.sv ----
// Constants, enums and carrier structs of the tag feature control.
// Assumes a Gen2 front end that decodes frames and checks CRC upstream.
package rtfc_pkg;

  localparam logic [7:0]  CW_WORD       = 8'h20;
  localparam logic [15:0] SEL_EPC_TID   = 16'h0203;
  localparam logic [15:0] SEL_BRAND     = 16'h0204;
  localparam logic [15:0] SEL_PSF       = 16'h020f;
  localparam int          B_SA_DIS      = 7;
  localparam int          B_BS_MAX      = 9;
  localparam int          B_PSF         = 15;
  localparam logic [15:0] UNTR_OP       = 16'he200;
  localparam logic [4:0]  RST_EPC_LEN   = 5'h06;
  localparam logic        RST_SA_DIS    = 1'b0;
  localparam logic        RST_BS_MAX    = 1'b1;
  localparam logic        RST_PSF       = 1'b0;
  localparam logic        RST_RANGE     = 1'b0;
  localparam logic [7:0]  EPC_FIRST     = 8'h02;
  localparam logic [7:0]  TID_HIDE_FROM = 8'h02;
  localparam logic [1:0]  TID_SOME      = 2'h1;
  localparam logic [1:0]  TID_ALL       = 2'h2;
  localparam logic [1:0]  FIELD_RFU     = 2'h3;
  localparam logic [1:0]  RNG_NORMAL    = 2'h0;
  localparam logic [1:0]  RNG_TOGGLE    = 2'h1;
  localparam logic [1:0]  RNG_REDUCED   = 2'h2;
  localparam int          ECC_W         = 22;

  typedef enum logic [1:0] {
    BANK_RES = 2'h0, BANK_EPC = 2'h1, BANK_TID = 2'h2, BANK_USER = 2'h3
  } rtfc_bank_e;

  typedef enum logic [2:0] {
    TS_READY = 3'h0, TS_ARB = 3'h1, TS_REPLY = 3'h2, TS_ACKD = 3'h3,
    TS_OPEN = 3'h4, TS_SECURED = 3'h5, TS_KILLED = 3'h6
  } rtfc_state_e;

  typedef enum logic [1:0] {
    RK_EPC = 2'h0, RK_BRAND = 2'h1, RK_EPC_TID = 2'h2
  } rtfc_reply_e;

  typedef enum logic [1:0] {
    CAP_LOW = 2'h0, CAP_MID = 2'h1, CAP_HIGH = 2'h2
  } rtfc_cap_e;

  typedef struct packed {
    logic valid; logic truncate; rtfc_bank_e bank;
    logic [15:0] pointer; logic [7:0] length; logic mask;
  } rtfc_sel_s;

  typedef struct packed {
    logic valid; rtfc_bank_e bank; logic lock; logic pwd; logic margin_ok;
  } rtfc_lock_s;

  typedef struct packed {
    logic valid; logic single; rtfc_bank_e bank; logic [7:0] addr; logic [15:0] data;
  } rtfc_wr_s;

  typedef struct packed {
    logic valid; logic [15:0] opcode; logic [1:0] rfu; logic u; logic [5:0] epc;
    logic [1:0] tid; logic user; logic [1:0] range; logic [15:0] handle;
  } rtfc_untr_s;

  typedef struct packed {
    logic valid; rtfc_bank_e bank; logic [7:0] addr; logic [ECC_W-1:0] code;
  } rtfc_rd_s;

endpackage

// ---- core/rtfc_ecc.sv ----
// SECDED decoder for one 16-bit memory word (Hamming plus overall parity).
// Assumes bit 0 is overall parity and powers of two are check bits.
`timescale 1ns/1ps
`default_nettype none
module rtfc_ecc import rtfc_pkg::*; (
  input  wire logic [ECC_W-1:0] code,
  input  wire logic             en,
  output logic      [15:0]      data,
  output logic                  single,
  output logic                  double
);
  logic [4:0] syn;
  genvar k;
  generate
    for (k = 0; k < 5; k++) begin : g_syn
      always_comb begin
        syn[k] = 1'b0;
        for (int p = 1; p < ECC_W; p++) begin
          if (((p >> k) & 1) == 1) syn[k] = syn[k] ^ code[p];
        end
      end
    end
  endgenerate

  always_comb begin
    logic [ECC_W-1:0] fixed;
    int j;
    fixed  = code;
    j      = 0;
    single = 1'b0;
    double = 1'b0;
    data   = 16'h0000;
    if (en) begin
      if (syn != 5'h00 && (^code) && syn < 5'd22) begin
        single     = 1'b1;
        fixed[syn] = ~fixed[syn];
      end else if (syn != 5'h00) begin
        double = 1'b1; // Raw word goes out untouched
      end else if (^code) begin
        single = 1'b1;
      end
    end
    for (int p = 1; p < ECC_W; p++) begin
      if ((p & (p - 1)) != 0) begin
        data[j[3:0]] = fixed[p];
        j = j + 1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- core/rtfc_self_adjust.sv ----
// Startup input capacitance stepper: low, then centre, then high.
// Assumes step pulses come from the analog front end on the same clock.
`timescale 1ns/1ps
`default_nettype none
module rtfc_self_adjust import rtfc_pkg::*; (
  input  wire logic      clk,
  input  wire logic      rstn,
  input  wire logic      disable_adj,
  input  wire logic      step,
  output rtfc_cap_e      cap
);
  rtfc_cap_e cap_reg;
  rtfc_cap_e cap_next;

  always_comb begin
    cap_next = cap_reg;
    if (disable_adj) begin
      cap_next = CAP_MID;
    end else if (step) begin
      case (cap_reg)
        CAP_LOW:  cap_next = CAP_MID;
        CAP_MID:  cap_next = CAP_HIGH;
        CAP_HIGH: cap_next = CAP_HIGH;
        default:  cap_next = CAP_LOW;
      endcase
    end
  end

  // Starts at the lowest value after every power up
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cap_reg <= CAP_LOW;
    end else begin
      cap_reg <= cap_next;
    end
  end

  assign cap = cap_reg;
endmodule
`default_nettype wire

// ---- verification/rtfc_monitor.sv ----
// Port checker of the tag feature control.
// Assumes it is bound into rtfc_top.
`timescale 1ns/1ps
`default_nettype none
module rtfc_monitor import rtfc_pkg::*; #(
  parameter logic [15:0] BRAND_CODE = 16'h5a3c
) (
  input wire logic        clk,
  input wire logic        rstn,
  input wire rtfc_state_e tag_state,
  input wire rtfc_sel_s   sel,
  input wire rtfc_lock_s  lock,
  input wire rtfc_untr_s  untr,
  input wire logic [15:0] rn16,
  input wire logic [95:0] tid_rom,
  input wire logic        sel_done,
  input wire logic        sel_match,
  input wire logic        lock_done,
  input wire logic        lock_error,
  input wire logic        rd_valid,
  input wire logic [15:0] rd_data,
  input wire logic        rd_overrun,
  input wire logic        reply_valid,
  input wire rtfc_reply_e reply_kind,
  input wire logic [15:0] brand_word,
  input wire logic        untr_done,
  input wire logic        state_valid,
  input wire rtfc_state_e state_next,
  input wire logic [95:0] preset_epc
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  sequence lock_bad_s;
    lock.valid && lock.lock && !lock.margin_ok && lock.bank != BANK_TID;
  endsequence
  sequence brand_sel_s;
    sel.valid && !sel.truncate && sel.bank == BANK_EPC && sel.pointer == SEL_BRAND
      && sel.length == 8'h01 && sel.mask;
  endsequence
  chk_lock_margin: assert property (lock_bad_s |=> lock_error && !lock_done)
    else $error("lock margin error missing");
  chk_brand_xor: assert property (reply_valid && reply_kind == RK_BRAND
    |-> brand_word == (BRAND_CODE ^ $past(rn16))) else $error("brand not scrambled");
  chk_sel_ignore: assert property (sel.valid && (sel.truncate || !sel.mask
    || sel.length != 8'h01) |=> !sel_done) else $error("bad select taken");
  chk_brand_match: assert property (brand_sel_s |=> sel_done && sel_match)
    else $error("brand select no match");
  chk_untr_fallback: assert property (untr.valid && untr.opcode == UNTR_OP
    && tag_state inside {TS_ARB, TS_REPLY, TS_ACKD} |=> state_valid && state_next == TS_ARB)
    else $error("untraceable state wrong");
  chk_untr_quiet: assert property (untr.valid && tag_state != TS_SECURED
    |=> !untr_done) else $error("untraceable replied");
  chk_preset_epc: assert property ($past(rstn, 2) |-> preset_epc[63:48] == 16'h0000
    && preset_epc[47:0] == $past(tid_rom[47:0])) else $error("preset epc wrong");
  chk_hidden_read: assert property (rd_overrun |-> rd_valid && rd_data == 16'h0000)
    else $error("overrun read wrong");
endmodule
bind rtfc_top rtfc_monitor #(.BRAND_CODE(BRAND_CODE)) rtfc_monitor_inst (.*);
`default_nettype wire

// ---- verification/rtfc_reader.sv ----
// Reader model: issues decoded Select, Lock, Write, Untraceable, ACK.
// Assumes the tag samples on the rising edge; drives at falling edge.
`timescale 1ns/1ps
`default_nettype none
module rtfc_reader import rtfc_pkg::*; (
  input  wire logic       clk,
  output var rtfc_sel_s   sel,
  output var rtfc_lock_s  lock,
  output var rtfc_wr_s    wr,
  output var rtfc_untr_s  untr,
  output var logic        ack_pulse
);
  initial begin
    sel = '0;
    lock = '0;
    wr = '0;
    untr = '0;
    ack_pulse = 1'b0;
  end
  task automatic sel_cmd(input logic [15:0] p, input logic tr);
    @(negedge clk);
    sel = '{1'b1, tr, BANK_EPC, p, 8'h01, 1'b1};
    @(negedge clk);
    sel = '0;
  endtask
  task automatic lock_cmd(input rtfc_bank_e b, input logic pw, input logic ok);
    @(negedge clk);
    lock = '{1'b1, b, 1'b1, pw, ok};
    @(negedge clk);
    lock = '0;
  endtask
  task automatic wr_cmd(input logic s, input rtfc_bank_e b, input logic [15:0] d);
    @(negedge clk);
    wr = '{1'b1, s, b, (b == BANK_EPC) ? CW_WORD : 8'h00, d};
    @(negedge clk);
    wr = '0;
  endtask
  // Handle left zero: CRC and handle are checked upstream
  task automatic untr_cmd(input logic [5:0] e, input logic [1:0] t, input logic [1:0] r);
    @(negedge clk);
    untr = '{1'b1, UNTR_OP, 2'b00, 1'b1, e, t, 1'b0, r, 16'h0000};
    @(negedge clk);
    untr = '0;
  endtask
  task automatic ack_cmd();
    @(negedge clk);
    ack_pulse = 1'b1;
    @(negedge clk);
    ack_pulse = 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- verification/tb_rtfc_top.sv ----
// Bench of the tag feature control: reader model plus memory read port.
// Assumes all commands are single-cycle pulses at the falling edge.
`timescale 1ns/1ps
`default_nettype none
module tb_rtfc_top import rtfc_pkg::*; ();
  localparam logic [15:0] RN = 16'h3c5a;
  localparam logic [15:0] D = 16'hb4e1;
  localparam logic [95:0] TID = 96'h1234_5678_2000_9abc_def0_1356;
  logic        clk, rstn, sa_step, ack_pulse, epc_permalocked;
  rtfc_state_e tag_state, state_next;
  rtfc_rd_s    rd;
  rtfc_sel_s   sel;
  rtfc_lock_s  lock;
  rtfc_wr_s    wr;
  rtfc_untr_s  untr;
  logic [15:0] conf_word, rd_data, pc_word, brand_word;
  logic        sel_done, sel_match, lock_done, lock_error, rd_overrun;
  logic        untr_done, backscatter_max, range_reduced, rd_valid, reply_valid, state_valid;
  rtfc_reply_e reply_kind;
  rtfc_cap_e   cap_sel;
  logic [95:0] preset_epc;
  rtfc_bank_e  bk;
  int          o, fail_count = 0, cmp_count = 0, cyc = 0;
  rtfc_top rtfc_top_inst (.rn16(RN), .tid_rom(TID), .pc_low(11'h123), .*);
  rtfc_reader rdr (.*);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [95:0] s, input logic [95:0] e);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %0t seen %0h expected %0h", $time, s, e);
    end
  endtask
  task automatic print_verdict();
    if (fail_count == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      print_verdict();
    end
  end
  // Hamming positions, data LSB first, bit 0 overall parity
  function automatic logic [21:0] enc(input logic [15:0] d);
    logic [21:0] c;
    int k;
    c = '0;
    k = 0;
    for (int i = 3; i < 22; i++)
      if ((i & (i - 1)) != 0) begin
        c[i] = d[k];
        k++;
      end
    for (int p = 1; p < 22; p = p * 2)
      for (int i = 3; i < 22; i++)
        if ((i & p) != 0 && i != p)
          c[p] = c[p] ^ c[i];
    c[0] = ^c;
    return c;
  endfunction
  task automatic rd_cmd(input rtfc_bank_e b, input logic [7:0] a, input logic [21:0] c);
    @(negedge clk);
    rd = '{1'b1, b, a, c};
    @(negedge clk);
    rd = '0;
  endtask
  task automatic step();
    @(negedge clk);
    sa_step = 1'b1;
    @(negedge clk);
    sa_step = 1'b0;
  endtask
  initial begin
    rstn = 1'b0;
    sa_step = 1'b0;
    epc_permalocked = 1'b0;
    rd = '0;
    tag_state = TS_OPEN;
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    repeat (2) @(negedge clk);
    chk(conf_word & 16'h8280, 16'h0200);
    chk(cap_sel, CAP_LOW);
    chk(preset_epc, {TID[95:64], 16'h0000, TID[47:0]});
    chk(^{preset_epc, TID[63:48]}, 1'b0);
    step();
    chk(cap_sel, CAP_MID);
    step();
    chk(cap_sel, CAP_HIGH);
    rdr.wr_cmd(1'b1, BANK_EPC, 16'h0000);
    rdr.wr_cmd(1'b0, BANK_EPC, 16'h0080);
    @(negedge clk);
    chk(conf_word[B_SA_DIS], 1'b0);
    rdr.wr_cmd(1'b1, BANK_EPC, 16'h0080);
    @(negedge clk);
    chk({conf_word[B_SA_DIS], cap_sel}, {1'b1, CAP_MID});
    rdr.wr_cmd(1'b1, BANK_EPC, 16'h0200);
    chk(backscatter_max, 1'b0);
    rdr.sel_cmd(SEL_BRAND, 1'b1);
    chk(sel_done, 1'b0);
    rdr.sel_cmd(SEL_BRAND, 1'b0);
    chk(sel_match, 1'b1);
    rdr.ack_cmd();
    chk(reply_kind, RK_BRAND);
    chk(brand_word, 16'h5a3c ^ RN);
    chk(pc_word, {5'h07, 11'h123});
    for (int b = 0; b < 2; b++) begin
      bk = b ? BANK_USER : BANK_EPC;
      o = b ? 12 : 0;
      rdr.lock_cmd(bk, 1'b1, 1'b0);
      chk(lock_error, 1'b1);
      rdr.lock_cmd(bk, 1'b1, 1'b1);
      chk(lock_done, 1'b1);
      @(negedge clk);
      chk(conf_word[o], 1'b1);
      rd_cmd(bk, 8'h03, enc(D) ^ 22'h000020);
      chk(rd_data, D);
      rd_cmd(bk, 8'h03, enc(D) ^ 22'h000006);
      chk(rd_data, D);
      @(negedge clk);
      chk(conf_word[o+1 +: 2], 2'b11);
    end
    tag_state = TS_SECURED;
    rdr.wr_cmd(1'b1, BANK_USER, 16'h1234);
    repeat (2) @(negedge clk);
    chk(conf_word[12], 1'b0);
    tag_state = TS_ARB;
    rdr.untr_cmd(6'h06, TID_SOME, RNG_NORMAL);
    chk({state_valid, untr_done, state_next}, {2'b10, TS_ARB});
    tag_state = TS_SECURED;
    rdr.untr_cmd(6'h06, TID_SOME, RNG_TOGGLE);
    chk({untr_done, range_reduced}, 2'b11);
    tag_state = TS_OPEN;
    rdr.untr_cmd(6'h06, TID_SOME, RNG_NORMAL);
    chk({state_valid, untr_done, state_next}, {2'b10, TS_OPEN});
    rd_cmd(BANK_TID, TID_HIDE_FROM, enc(D));
    chk({rd_valid, rd_overrun}, 2'b11);
    rd_cmd(BANK_TID, 8'h01, enc(D));
    chk(rd_overrun, 1'b0);
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    repeat (2) @(negedge clk);
    chk(range_reduced, 1'b0);
    tag_state = TS_SECURED;
    rdr.untr_cmd(6'h00, 2'h0, RNG_NORMAL);
    rdr.sel_cmd(SEL_EPC_TID, 1'b0);
    chk(sel_match, 1'b1);
    rdr.ack_cmd();
    chk({reply_valid, reply_kind, pc_word}, {1'b1, RK_EPC_TID, 16'h0123});
    rdr.sel_cmd(SEL_PSF, 1'b0);
    chk({sel_done, sel_match}, 2'b10);
    rdr.ack_cmd();
    chk(reply_valid, 1'b0);
    epc_permalocked = 1'b1;
    rdr.wr_cmd(1'b1, BANK_EPC, 16'h8000);
    epc_permalocked = 1'b0;
    rdr.wr_cmd(1'b1, BANK_EPC, 16'h8000);
    rdr.ack_cmd();
    chk(reply_valid, 1'b1);
    print_verdict();
  end
endmodule
`default_nettype wire
